// file: src/seq_pkg.sv
// shared constants and types for the startup sequencer and reference mux
package seq_pkg;

  // settling and calibration lengths, counted in phase-detector or feedback edges
  localparam int unsigned REF_SETTLE_CYCLES = 32'h0001_0000;
  localparam int unsigned FB_SETTLE_CYCLES = 32'h0001_0000;
  localparam int unsigned COUNTER_WIDTH_SETTING = 32'h0000_0020;
  localparam int unsigned CAL_CYCLES = 32'h0002_0000;

  // lock indicator window after the outputs turn on
  localparam int unsigned LOCK_MIN_CYCLES = 32'h0000_0800;
  localparam int unsigned LOCK_MAX_CYCLES = 32'h0000_0A00;
  localparam int unsigned LOCK_CYCLES = 32'h0000_0901;

  // reference mux: dead time around a switch, and primary loss timeout in clk_sys cycles
  localparam int unsigned SWITCH_GAP = 32'h0000_0002;
  localparam int unsigned LOSS_LIMIT = 32'h0000_0040;

  // width of the shared step counter, enough for the calibration length
  localparam int unsigned SEQ_CNT_W = 32'h0000_0012;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_XTAL = 3'h1,
    ST_REF = 3'h2,
    ST_FB = 3'h3,
    ST_CAL = 3'h4,
    ST_RUN = 3'h5
  } seq_state_t;

endpackage

// file: src/ref_mux.sv
// glitch-free reference input selector with automatic and manual modes
module ref_mux #(
  parameter int unsigned GAP = seq_pkg::SWITCH_GAP,
  parameter int unsigned LOSS = seq_pkg::LOSS_LIMIT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // pins from outside the clock domain
  input wire logic interface_mode_pin,
  input wire logic ref_select_pin,
  input wire logic primary_reference,
  input wire logic secondary_reference,
  // configuration bits
  input wire logic mux_mode_bit,
  input wire logic mux_input_bit,
  input wire logic pin_auto_cfg,
  // selection state
  output logic ref_edge_q,
  output logic sel_q,
  output logic gate_q,
  output logic primary_lost
);
  import seq_pkg::*;

  localparam int unsigned GW = $clog2(GAP + 1);
  localparam int unsigned LW = $clog2(LOSS + 1);
  localparam logic [GW-1:0] GAP_END = GW'(GAP);
  localparam logic [LW-1:0] LOSS_END = LW'(LOSS);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers; stage three only feeds the edge detectors
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  assign pin_raw = {interface_mode_pin, ref_select_pin, secondary_reference, primary_reference};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else if (ce) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic pri_edge;
  logic sec_edge;
  logic sel_pin;
  logic pin_mode;
  assign pri_edge = s2_q[0] & ~s3_q[0];
  assign sec_edge = s2_q[1] & ~s3_q[1];
  assign sel_pin = s2_q[2];
  assign pin_mode = s2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // mode decode, primary loss watch and switch sequencing
  logic [LW-1:0] loss_q;
  logic [LW-1:0] loss_d;
  logic [GW-1:0] gap_q;
  logic [GW-1:0] gap_d;
  logic sel_d;
  logic gate_d;
  logic edge_d;
  logic auto_mode;
  logic manual_sec;
  logic want_sec;

  assign primary_lost = (loss_q == LOSS_END);

  always_comb begin
    auto_mode = 1'b0;
    manual_sec = 1'b0;
    if (pin_mode) begin
      auto_mode = pin_auto_cfg;
      manual_sec = sel_pin;
    end else if (!mux_mode_bit) begin
      auto_mode = 1'b1;
    end else if (!mux_input_bit) begin
      manual_sec = 1'b0;
    end else begin
      manual_sec = sel_pin;
    end
    // in automatic mode the primary wins whenever it is present; manual modes follow manual_sec
    want_sec = auto_mode ? primary_lost : manual_sec;

    loss_d = pri_edge ? '0 : (primary_lost ? loss_q : loss_q + 1'b1);
    sel_d = sel_q;
    gate_d = gate_q;
    gap_d = gap_q;
    // break before make: the gate closes, a dead time passes, the select moves,
    // another dead time passes, then the gate reopens; no partial edge can leak
    if (sel_q != want_sec) begin
      gate_d = 1'b0;
      if (!gate_q && gap_q == GAP_END) begin
        sel_d = want_sec;
        gap_d = '0;
      end else if (!gate_q) begin
        gap_d = gap_q + 1'b1;
      end
    end else if (!gate_q) begin
      if (gap_q == GAP_END) begin
        gate_d = 1'b1;
        gap_d = '0;
      end else begin
        gap_d = gap_q + 1'b1;
      end
    end
    edge_d = gate_q & (sel_q ? sec_edge : pri_edge);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loss_q <= '0;
      gap_q <= '0;
      sel_q <= 1'b0;
      gate_q <= 1'b1;
      ref_edge_q <= 1'b0;
    end else if (ce) begin
      loss_q <= loss_d;
      gap_q <= gap_d;
      sel_q <= sel_d;
      gate_q <= gate_d;
      ref_edge_q <= edge_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_gate_closed_switch: assert property ($changed(sel_q) |-> !gate_q && !$past(gate_q))
    else $error("select moved while gate open");
  chk_auto_primary: assert property ((ce && !pin_mode && !mux_mode_bit && !primary_lost) [*8] |-> !sel_q)
    else $error("auto mode left a present primary");
  chk_forced_primary: assert property ((ce && !pin_mode && mux_mode_bit && !mux_input_bit) [*8] |-> !sel_q)
    else $error("forced primary not selected");
  chk_pin_select: assert property ((ce && !pin_mode && mux_mode_bit && mux_input_bit && sel_pin) [*8] |-> sel_q)
    else $error("select pin high did not pick secondary");
  chk_pin_mode_sec: assert property ((ce && pin_mode && !pin_auto_cfg && sel_pin) [*8] |-> sel_q)
    else $error("pin mode secondary not selected");
  chk_auto_fallback: assert property ((ce && !pin_mode && !mux_mode_bit && primary_lost) [*8] |-> sel_q)
    else $error("auto mode did not fall back to secondary");
  cov_auto_switch: cover property (!pin_mode && !mux_mode_bit && $rose(sel_q));

endmodule

// file: src/startup_sequencer.sv
// startup and calibration sequencer with output enable, lock indicator and reference mux
module startup_sequencer #(
  parameter int unsigned REF_SETTLE = seq_pkg::REF_SETTLE_CYCLES,
  parameter int unsigned FB_SETTLE = seq_pkg::FB_SETTLE_CYCLES,
  parameter int unsigned CAL_LEN = seq_pkg::CAL_CYCLES,
  parameter int unsigned LOCK_LEN = seq_pkg::LOCK_CYCLES,
  parameter int unsigned GAP = seq_pkg::SWITCH_GAP,
  parameter int unsigned LOSS = seq_pkg::LOSS_LIMIT
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // control and monitor pins, asynchronous
  input wire logic active_low_reset_pin,
  input wire logic power_down_pin,
  input wire logic output_sync_pin,
  input wire logic supply_good_pin,
  input wire logic crystal_in_use_pin,
  input wire logic crystal_swing_ok_pin,
  input wire logic interface_mode_pin,
  input wire logic ref_select_pin,
  // reference and feedback clocks, sampled
  input wire logic primary_reference,
  input wire logic secondary_reference,
  input wire logic feedback_clock,
  // configuration bits from the serial register bank
  input wire logic sw_reset_bit,
  input wire logic mux_mode_bit,
  input wire logic mux_input_bit,
  input wire logic pin_auto_cfg,
  input wire logic lock_route_zero,
  input wire logic lock_route_one,
  // status
  output logic clk_out_en,
  output logic cal_active,
  output logic lock_ind,
  output logic load_defaults,
  output logic status_output_zero,
  output logic status_output_one,
  output logic sel_secondary,
  output logic mux_gate,
  output logic primary_lost,
  output seq_pkg::seq_state_t seq_state
);
  import seq_pkg::*;

  localparam logic [SEQ_CNT_W-1:0] REF_LAST = SEQ_CNT_W'(REF_SETTLE - 1);
  localparam logic [SEQ_CNT_W-1:0] FB_LAST = SEQ_CNT_W'(FB_SETTLE - 1);
  localparam logic [SEQ_CNT_W-1:0] CAL_LAST = SEQ_CNT_W'(CAL_LEN - 1);
  localparam logic [SEQ_CNT_W-1:0] LOCK_LAST = SEQ_CNT_W'(LOCK_LEN - 1);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the feedback bit gets a third stage for edge detection
  logic [6:0] pin_raw;
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic fb_s3_q;
  assign pin_raw = {feedback_clock, crystal_swing_ok_pin, crystal_in_use_pin,
                    supply_good_pin, output_sync_pin, power_down_pin, active_low_reset_pin};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
      fb_s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      fb_s3_q <= s2_q[6];
    end
  end

  logic rst_pin_s;
  logic pdn_s;
  logic sync_s;
  logic por_s;
  logic xtal_use_s;
  logic xtal_ok_s;
  logic fb_edge;
  logic pin_hold;
  assign rst_pin_s = s2_q[0];
  assign pdn_s = s2_q[1];
  assign sync_s = s2_q[2];
  assign por_s = s2_q[3];
  assign xtal_use_s = s2_q[4];
  assign xtal_ok_s = s2_q[5];
  assign fb_edge = s2_q[6] & ~fb_s3_q;
  // any of the three hardware reset causes holds the sequence and arms a reload
  assign pin_hold = !rst_pin_s || !pdn_s || !por_s;

  ////////////////////////////////////////////////////////////////////////////
  // reference mux; its gated edge is the phase-detector tick
  logic pfd_edge;
  logic sel_q;
  logic gate_q;

  ref_mux #(
    .GAP(GAP),
    .LOSS(LOSS)
  ) u_ref_mux (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .interface_mode_pin(interface_mode_pin),
    .ref_select_pin(ref_select_pin),
    .primary_reference(primary_reference),
    .secondary_reference(secondary_reference),
    .mux_mode_bit(mux_mode_bit),
    .mux_input_bit(mux_input_bit),
    .pin_auto_cfg(pin_auto_cfg),
    .ref_edge_q(pfd_edge),
    .sel_q(sel_q),
    .gate_q(gate_q),
    .primary_lost(primary_lost)
  );

  assign sel_secondary = sel_q;
  assign mux_gate = gate_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequence state, shared step counter and registered outputs
  seq_state_t state_q;
  seq_state_t state_d;
  logic [SEQ_CNT_W-1:0] cnt_q;
  logic [SEQ_CNT_W-1:0] cnt_d;
  logic lock_q;
  logic lock_d;
  logic reload_q;
  logic reload_d;
  logic load_q;
  logic load_d;
  logic out_en_q;
  logic out_en_d;
  logic cal_q;
  logic cal_d;
  logic stat0_q;
  logic stat0_d;
  logic stat1_q;
  logic stat1_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    lock_d = lock_q;
    reload_d = reload_q;
    load_d = 1'b0;
    if (pin_hold) begin
      state_d = ST_OFF;
      cnt_d = '0;
      lock_d = 1'b0;
      reload_d = 1'b1;
    end else if (sw_reset_bit) begin
      // held in reset with outputs off; no reload is armed
      state_d = ST_OFF;
      cnt_d = '0;
      lock_d = 1'b0;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_d = ST_XTAL;
          load_d = reload_q;
          reload_d = 1'b0;
        end
        ST_XTAL: begin
          if (!xtal_use_s || xtal_ok_s) begin
            state_d = ST_REF;
          end
        end
        ST_REF: begin
          if (pfd_edge) begin
            if (cnt_q == REF_LAST) begin
              state_d = ST_FB;
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        ST_FB: begin
          if (fb_edge) begin
            if (cnt_q == FB_LAST) begin
              state_d = ST_CAL;
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        ST_CAL: begin
          if (pfd_edge) begin
            if (cnt_q == CAL_LAST) begin
              state_d = ST_RUN;
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        ST_RUN: begin
          // the analog loop is not observed; lock is a fixed edge count after turn-on
          if (pfd_edge && !lock_q) begin
            if (cnt_q == LOCK_LAST) begin
              lock_d = 1'b1;
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        default: begin
          state_d = ST_OFF;
          cnt_d = '0;
        end
      endcase
    end
    out_en_d = (state_d == ST_RUN) && sync_s;
    cal_d = (state_d == ST_CAL);
    stat0_d = lock_d && lock_route_zero;
    stat1_d = lock_d && lock_route_one;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      cnt_q <= '0;
      lock_q <= 1'b0;
      reload_q <= 1'b1;
      load_q <= 1'b0;
      out_en_q <= 1'b0;
      cal_q <= 1'b0;
      stat0_q <= 1'b0;
      stat1_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      reload_q <= reload_d;
      load_q <= load_d;
      out_en_q <= out_en_d;
      cal_q <= cal_d;
      stat0_q <= stat0_d;
      stat1_q <= stat1_d;
    end
  end

  assign clk_out_en = out_en_q;
  assign cal_active = cal_q;
  assign lock_ind = lock_q;
  assign load_defaults = load_q;
  assign status_output_zero = stat0_q;
  assign status_output_one = stat1_q;
  assign seq_state = state_q;

  ////////////////////////////////////////////////////////////////////////////
  chk_reset_pin_off: assert property ((ce && !rst_pin_s) |=> !out_en_q && state_q == ST_OFF)
    else $error("outputs not held off under reset pin");
  chk_auto_start: assert property ((ce && state_q == ST_OFF && !pin_hold && !sw_reset_bit) |=> state_q == ST_XTAL)
    else $error("sequence did not start after release");
  chk_power_down: assert property ((ce && !pdn_s) |=> state_q == ST_OFF && !lock_q && !out_en_q)
    else $error("power down did not stop the sequence");
  chk_supply_hold: assert property ((ce && !por_s) |=> state_q == ST_OFF)
    else $error("left reset with supply low");
  chk_xtal_wait: assert property ((ce && state_q == ST_XTAL && xtal_use_s && !xtal_ok_s && !pin_hold && !sw_reset_bit) |=> state_q == ST_XTAL)
    else $error("crystal stage left without swing");
  chk_ref_count: assert property ((state_q == ST_FB && $past(state_q) == ST_REF) |-> $past(cnt_q) == REF_LAST && $past(pfd_edge))
    else $error("reference count ended early");
  chk_fb_count: assert property ((state_q == ST_CAL && $past(state_q) == ST_FB) |-> $past(cnt_q) == FB_LAST && $past(fb_edge))
    else $error("feedback count ended early");
  chk_cal_length: assert property ((state_q == ST_RUN && $past(state_q) == ST_CAL) |-> $past(cnt_q) == CAL_LAST && $past(pfd_edge))
    else $error("calibration length wrong");
  chk_outputs_on: assert property ((state_q == ST_RUN && $past(state_q) == ST_CAL) |-> out_en_q == $past(sync_s) && !lock_q)
    else $error("outputs not enabled at calibration end");
  chk_lock_count: assert property ($rose(lock_q) |-> state_q == ST_RUN && $past(cnt_q) == LOCK_LAST)
    else $error("lock rose at wrong count");
  chk_reload_pulse: assert property ((ce && state_q == ST_OFF && !pin_hold && !sw_reset_bit) |=> load_q == $past(reload_q))
    else $error("default reload pulse wrong");
  chk_sw_keep: assert property ((ce && sw_reset_bit && !pin_hold) ##1 (ce && !sw_reset_bit && !pin_hold) |=> !load_q)
    else $error("software reset reloaded defaults");
  cov_reach_run: cover property (state_q == ST_CAL ##1 state_q == ST_RUN);
  cov_lock: cover property ($rose(lock_q) && stat0_q);
  cov_sw_restart: cover property (sw_reset_bit ##1 !sw_reset_bit ##1 state_q == ST_XTAL);

endmodule

// file: tb/host_model.sv
// reference and feedback clock source standing in for the host board
module host_model #(
  parameter int PRI_PER = 8,
  parameter int SEC_PER = 9,
  parameter int FB_PER = 8
) (
  // clock
  input wire logic clk_sys,
  // bench control
  input wire logic pri_on,
  // clocks into the device
  output logic primary_reference = 1'b0,
  output logic secondary_reference = 1'b0,
  output logic feedback_clock = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int pc = 0;
  int sc = 0;
  int fc = 0;
  ////////////////////////////////////////////////////////////
  // periods 8 and 9 keep the two inputs 12.5 percent apart
  always @(posedge clk_sys) begin
    pc <= (pc + 1) % PRI_PER;
    sc <= (sc + 1) % SEC_PER;
    fc <= (fc + 1) % FB_PER;
    // a lost primary stands low instead of freezing mid-cycle
    primary_reference <= pri_on && (pc < PRI_PER - PRI_PER / 2);
    secondary_reference <= sc < SEC_PER - SEC_PER / 2;
    feedback_clock <= fc < FB_PER - FB_PER / 2;
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the startup sequencer and reference mux
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import seq_pkg::*;
  localparam int RS = 8;
  localparam int FS = 8;
  localparam int CL = 16;
  localparam int LL = 5;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic active_low_reset_pin = 1'b0;
  logic power_down_pin = 1'b1;
  logic output_sync_pin = 1'b1;
  logic supply_good_pin = 1'b1;
  logic crystal_in_use_pin = 1'b0;
  logic crystal_swing_ok_pin = 1'b0;
  logic interface_mode_pin = 1'b0;
  logic ref_select_pin = 1'b0;
  logic sw_reset_bit = 1'b0;
  logic mux_mode_bit = 1'b0;
  logic mux_input_bit = 1'b0;
  logic pin_auto_cfg = 1'b1;
  logic lock_route_zero = 1'b1;
  logic lock_route_one = 1'b0;
  logic pri_on = 1'b1;
  wire logic primary_reference, secondary_reference, feedback_clock;
  logic clk_out_en, cal_active, lock_ind, load_defaults;
  logic status_output_zero, status_output_one, sel_secondary, mux_gate, primary_lost;
  seq_state_t seq_state;
  int errors = 0;
  int checks = 0;
  int ecnt = 0;
  int fcnt = 0;
  int lds = 0;
  int lock_e = 0;
  int st_ref[8];
  int st_fb[8];
  logic pr, fr, lk, gq, sq;
  seq_state_t last_st = ST_OFF;

  initial forever #12.5 clk_sys = ~clk_sys;

  host_model i_host_model (.clk_sys, .pri_on, .primary_reference, .secondary_reference,
    .feedback_clock);

  startup_sequencer #(.REF_SETTLE(RS), .FB_SETTLE(FS), .CAL_LEN(CL), .LOCK_LEN(LL))
  i_startup_sequencer (.clk_sys, .rst_n, .ce, .active_low_reset_pin, .power_down_pin,
    .output_sync_pin, .supply_good_pin, .crystal_in_use_pin, .crystal_swing_ok_pin,
    .interface_mode_pin, .ref_select_pin, .primary_reference, .secondary_reference,
    .feedback_clock, .sw_reset_bit, .mux_mode_bit, .mux_input_bit, .pin_auto_cfg,
    .lock_route_zero, .lock_route_one, .clk_out_en, .cal_active, .lock_ind, .load_defaults,
    .status_output_zero, .status_output_one, .sel_secondary, .mux_gate, .primary_lost,
    .seq_state);

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // raw edges lead the synchronised ones, so counts may slip by one
  function automatic int near(input int seen, input int exp);
    return (seen >= exp - 1 && seen <= exp + 1) ? exp : seen;
  endfunction

  task automatic give_verdict;
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wait_st(input seq_state_t s);
    int i;
    for (i = 0; i < 4000 && seq_state !== s; i++) cyc(1);
    if (seq_state !== s) begin
      check(seq_state, s);
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////
  // edge counts per state and since outputs came on
  always @(posedge clk_sys) begin
    if (primary_reference && !pr) ecnt++;
    if (feedback_clock && !fr) fcnt++;
    pr = primary_reference;
    fr = feedback_clock;
    if (load_defaults === 1'b1) lds++;
    if (gq === 1'b1) check(sel_secondary, sq);
    gq = mux_gate;
    sq = sel_secondary;
    if (lock_ind === 1'b1 && lk !== 1'b1) lock_e = ecnt;
    lk = lock_ind;
    if (seq_state !== last_st) begin
      st_ref[last_st] = ecnt;
      st_fb[last_st] = fcnt;
      ecnt = 0;
      fcnt = 0;
      last_st = seq_state;
    end
  end

  task automatic full_run;
    wait_st(ST_CAL);
    check(cal_active, 1'b1);
    wait_st(ST_RUN);
    cyc(2);
    check(near(st_ref[ST_REF], RS), RS);
    check(near(st_fb[ST_FB], FS), FS);
    check(near(st_ref[ST_CAL], CL), CL);
    check(clk_out_en, 1'b1);
    check(cal_active, 1'b0);
    cyc(8 * LL + 40);
    check(lock_ind, 1'b1);
    check(near(lock_e, LL), LL);
    check(status_output_zero, lock_route_zero);
    check(status_output_one, lock_route_one);
    // the host parks the outputs with the sync pin instead of the reset pin
    output_sync_pin = 1'b0;
    cyc(4);
    check(clk_out_en, 1'b0);
    check(lock_ind, 1'b1);
    output_sync_pin = 1'b1;
    cyc(4);
    check(clk_out_en, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    int k;
    logic [31:0] r;
    logic lost;
    logic want;
    r = $urandom(32'h69eb229d);
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    check(seq_state, ST_OFF);
    check(mux_gate, 1'b1);
    check(sel_secondary, 1'b0);
    cyc(30);
    // each hold source in turn: reset pin, power-down pin, supply monitor
    for (k = 0; k < 3; k++) begin
      lds = 0;
      // walk the lock routing through zero only, one only, then both
      lock_route_zero = (k != 1);
      lock_route_one = (k != 0);
      case (k)
        0: active_low_reset_pin = 1'b0;
        1: power_down_pin = 1'b0;
        default: supply_good_pin = 1'b0;
      endcase
      cyc(20);
      check(seq_state, ST_OFF);
      check(clk_out_en, 1'b0);
      check(lock_ind, 1'b0);
      {active_low_reset_pin, power_down_pin, supply_good_pin} = 3'b111;
      full_run();
      check(lds, 1);
    end
    // clock enable low freezes everything, even a power-down and a software reset
    ce = 1'b0;
    power_down_pin = 1'b0;
    sw_reset_bit = 1'b1;
    cyc(6);
    check(seq_state, ST_RUN);
    check(clk_out_en, 1'b1);
    power_down_pin = 1'b1;
    sw_reset_bit = 1'b0;
    ce = 1'b1;
    cyc(4);
    check(seq_state, ST_RUN);
    check(lock_ind, 1'b1);
    // software reset with a crystal that is slow to swing
    crystal_in_use_pin = 1'b1;
    sw_reset_bit = 1'b1;
    cyc(6);
    check(seq_state, ST_OFF);
    check(clk_out_en, 1'b0);
    lds = 0;
    sw_reset_bit = 1'b0;
    cyc(40);
    check(seq_state, ST_XTAL);
    crystal_swing_ok_pin = 1'b1;
    full_run();
    check(lds, 0);
    // random mux settings, with the primary present or absent
    for (k = 0; k < 40; k++) begin
      r = $urandom;
      {interface_mode_pin, mux_mode_bit, mux_input_bit, pin_auto_cfg} = r[3:0];
      {ref_select_pin, pri_on} = r[5:4];
      cyc(150);
      lost = !pri_on;
      if (interface_mode_pin)
        want = pin_auto_cfg ? lost : ref_select_pin;
      else
        want = !mux_mode_bit ? lost : (mux_input_bit & ref_select_pin);
      check(primary_lost, lost);
      check(sel_secondary, want);
    end
    give_verdict();
  end
endmodule
